// >>> verilog/hpp_pkg.sv
package hpp_pkg;

  // ---------------------------------------------------------------
  // register map (word index = byte address / 4 not used: plain port)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_STATUS    = 5'h01;
  localparam logic [4:0] ADDR_MODE_REQ  = 5'h02;
  localparam logic [4:0] ADDR_MODE_ACT  = 5'h03;
  localparam logic [4:0] ADDR_HM_METHOD = 5'h04;
  localparam logic [4:0] ADDR_HM_INPUT  = 5'h05;
  localparam logic [4:0] ADDR_HM_POL    = 5'h06;
  localparam logic [4:0] ADDR_HM_TARGET = 5'h07;
  localparam logic [4:0] ADDR_HM_VFAST  = 5'h08;
  localparam logic [4:0] ADDR_HM_VSLOW  = 5'h09;
  localparam logic [4:0] ADDR_HM_ACC    = 5'h0A;
  localparam logic [4:0] ADDR_HM_DEC    = 5'h0B;
  localparam logic [4:0] ADDR_HM_OFFSET = 5'h0C;
  localparam logic [4:0] ADDR_PP_TARGET = 5'h0D;
  localparam logic [4:0] ADDR_PP_VEL    = 5'h0E;
  localparam logic [4:0] ADDR_PP_ACC    = 5'h0F;
  localparam logic [4:0] ADDR_PP_DEC    = 5'h10;
  localparam logic [4:0] ADDR_VEL_LIMIT = 5'h11;
  localparam logic [4:0] ADDR_POS_MIN   = 5'h12;
  localparam logic [4:0] ADDR_POS_MAX   = 5'h13;
  localparam logic [4:0] ADDR_TGT_VEL   = 5'h14;
  localparam logic [4:0] ADDR_POS_ACT   = 5'h15;
  localparam logic [4:0] ADDR_VEL_ACT   = 5'h16;
  localparam logic [4:0] ADDR_ACC_ACT   = 5'h17;

  // ---------------------------------------------------------------
  // operating modes and homing methods
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_POSITION = 8'h01;
  localparam logic [7:0] MODE_VELOCITY = 8'h03;
  localparam logic [7:0] MODE_HOMING   = 8'h06;
  localparam logic [7:0] METHOD_SWITCH = 8'h11;
  localparam logic [7:0] METHOD_HERE   = 8'h25;

  // ---------------------------------------------------------------
  // control and status bit positions
  // ---------------------------------------------------------------
  localparam int CW_FAULT_RST   = 7;
  localparam int SW_RDY_SW_ON   = 0;
  localparam int SW_SWITCHED_ON = 1;
  localparam int SW_OP_ENABLED  = 2;
  localparam int SW_FAULT       = 3;
  localparam int SW_QUICK_STOP  = 5;
  localparam int SW_SW_ON_DIS   = 6;
  localparam int SW_TGT_REACHED = 10;
  localparam int SW_LIMIT       = 11;
  localparam int SW_HOMED       = 12;

  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  typedef enum logic [2:0] {
    HPP_SW_ON_DISABLED,
    HPP_READY,
    HPP_SWITCHED_ON,
    HPP_OP_ENABLED,
    HPP_QUICK_STOP,
    HPP_FAULT
  } hpp_drive_t;

  typedef enum logic [2:0] {
    HPP_H_IDLE,
    HPP_H_FAST_OUT,
    HPP_H_FAST_BACK,
    HPP_H_SLOW,
    HPP_H_DONE
  } hpp_home_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } hpp_bus_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [31:0] vel;
    logic signed [31:0] acc;
  } hpp_motion_t;

endpackage

// >>> verilog/hpp_profile.sv
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
module hpp_profile #(
  parameter int NUM_INPUTS = 4
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // register port
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  input  wire logic [4:0]            bus_addr,
  input  wire logic [31:0]           bus_wdata,
  output logic      [31:0]           bus_rdata,
  // digital inputs from pins
  input  wire logic [NUM_INPUTS-1:0] din,
  // motion outputs
  output logic signed [31:0]         pos_out,
  output logic signed [31:0]         vel_out,
  output logic                       drive_enabled
);

  // ---------------------------------------------------------------
  // registers written by software, then active mode, read data and status flags
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg, mode_req_reg, method_reg, in_sel_reg, pol_reg;
  logic signed [31:0] hm_target_reg, hm_vfast_reg, hm_vslow_reg;
  logic signed [31:0] hm_acc_reg, hm_dec_reg, hm_offset_reg;
  logic signed [31:0] pp_target_reg, pp_vel_reg, pp_acc_reg, pp_dec_reg;
  logic signed [31:0] vel_limit_reg, pos_min_reg, pos_max_reg;
  logic signed [31:0] tgt_vel_reg;
  logic [7:0]         mode_act_reg;
  logic [31:0]        rdata_reg;
  logic               homed_reg, limit_reg, fault_rst_prev_reg;

  hpp_pkg::hpp_bus_t    bus;
  hpp_pkg::hpp_motion_t mot_reg, mot_next;
  hpp_pkg::hpp_drive_t  drv_reg, drv_next;
  hpp_pkg::hpp_home_t   hm_reg, hm_next;

  assign bus = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

  function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
    return v[31] ? -v : v;
  endfunction

  function automatic logic signed [31:0] clamp(
    input logic signed [31:0] v, input logic signed [31:0] lo,
    input logic signed [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ---------------------------------------------------------------
  // switch input synchroniser: three stages, change on agreement
  // ---------------------------------------------------------------
  logic [NUM_INPUTS-1:0] din_s1_reg, din_s2_reg, din_s3_reg, din_f_reg;
  always_ff @(posedge ref_clk) begin
    din_s1_reg <= din;
    din_s2_reg <= din_s1_reg;
    din_s3_reg <= din_s2_reg;
    if (rst) begin
      din_f_reg <= '0;
    end else begin
      din_f_reg <= (din_s2_reg & din_s3_reg) |
                   ((din_s2_reg | din_s3_reg) & din_f_reg);
    end
  end

  logic [1:0] in_idx;
  logic       sw_raw, sw_act, sw_prev_reg, sw_edge;
  assign in_idx  = in_sel_reg[1:0];
  assign sw_raw  = din_f_reg[in_idx];
  assign sw_act  = sw_raw ~^ pol_reg[0];
  assign sw_edge = sw_act & ~sw_prev_reg;

  // ---------------------------------------------------------------
  // drive state machine
  // ---------------------------------------------------------------
  logic [3:0] cw;
  logic       cw_written, fault_rise;
  assign cw         = ctrl_reg[3:0];
  assign cw_written = bus.wr && bus.addr == hpp_pkg::ADDR_CTRL;
  assign fault_rise = ctrl_reg[hpp_pkg::CW_FAULT_RST] & ~fault_rst_prev_reg;

  always_comb begin
    drv_next = drv_reg;
    case (drv_reg)
      hpp_pkg::HPP_FAULT: begin
        if (fault_rise) begin
          drv_next = hpp_pkg::HPP_SW_ON_DISABLED;
        end
      end
      default: begin
        if (!cw[1]) begin
          drv_next = hpp_pkg::HPP_SW_ON_DISABLED;
        end else if (!cw[2]) begin
          drv_next = hpp_pkg::HPP_QUICK_STOP;
        end else if (!cw[0]) begin
          drv_next = hpp_pkg::HPP_READY;
        end else if (!cw[3] && drv_reg != hpp_pkg::HPP_SW_ON_DISABLED) begin
          drv_next = hpp_pkg::HPP_SWITCHED_ON;
        end else if (cw[3] && drv_reg != hpp_pkg::HPP_SW_ON_DISABLED) begin
          drv_next = hpp_pkg::HPP_OP_ENABLED;
        end
      end
    endcase
  end

  logic op_en;
  assign op_en         = drv_reg == hpp_pkg::HPP_OP_ENABLED;
  assign drive_enabled = op_en;

  // ---------------------------------------------------------------
  // homing sequencer
  // ---------------------------------------------------------------
  logic mode_wr, home_req, home_ok;
  assign mode_wr  = bus.wr && bus.addr == hpp_pkg::ADDR_MODE_REQ;
  assign home_req = mode_wr && bus.wdata[7:0] == hpp_pkg::MODE_HOMING;
  assign home_ok  = home_req && op_en && mode_act_reg == hpp_pkg::MODE_POSITION;

  logic signed [31:0] hm_dir, dist_to_bound;
  assign hm_dir = hm_target_reg[31] ? -32'sd1 : 32'sd1;
  assign dist_to_bound = hm_target_reg - mot_reg.pos;

  always_comb begin
    hm_next = hm_reg;
    case (hm_reg)
      hpp_pkg::HPP_H_IDLE: begin
        if (home_ok && method_reg[7:0] == hpp_pkg::METHOD_SWITCH) begin
          hm_next = hpp_pkg::HPP_H_FAST_OUT;
        end
      end
      hpp_pkg::HPP_H_FAST_OUT: begin
        if (sw_edge) begin
          hm_next = hpp_pkg::HPP_H_FAST_BACK;
        end
      end
      hpp_pkg::HPP_H_FAST_BACK: begin
        if (sw_edge) begin
          hm_next = hpp_pkg::HPP_H_SLOW;
        end
      end
      hpp_pkg::HPP_H_SLOW: begin
        if (sw_edge) begin
          hm_next = hpp_pkg::HPP_H_DONE;
        end
      end
      default: hm_next = hpp_pkg::HPP_H_IDLE;
    endcase
    if (!op_en) begin
      hm_next = hpp_pkg::HPP_H_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // profile generator, open loop
  // ---------------------------------------------------------------
  logic               homing, vel_mode, stopping, lim_hit;
  logic signed [31:0] goal, vmax, acc, dec, vlim, vcmd, stop_dist, togo;
  logic signed [31:0] v_abs, v_step, v_new, p_new;
  logic [63:0]        brake_sq;

  assign homing   = hm_reg != hpp_pkg::HPP_H_IDLE;
  assign vel_mode = mode_act_reg == hpp_pkg::MODE_VELOCITY;
  assign stopping = !op_en || drv_reg == hpp_pkg::HPP_QUICK_STOP;
  assign goal = (hm_reg == hpp_pkg::HPP_H_FAST_BACK) ? -hm_target_reg :
                homing ? hm_target_reg : pp_target_reg;
  assign vmax = (hm_reg == hpp_pkg::HPP_H_SLOW) ? hm_vslow_reg :
                homing ? hm_vfast_reg : pp_vel_reg;
  assign acc  = homing ? hm_acc_reg : pp_acc_reg;
  assign dec  = homing ? hm_dec_reg : pp_dec_reg;
  assign vlim = (abs32(vmax) > vel_limit_reg) ? vel_limit_reg : abs32(vmax);

  assign v_abs    = abs32(mot_reg.vel);
  assign togo     = goal - mot_reg.pos;
  // stopping distance v*(v+dec)/(2*dec), computed with a divider
  assign brake_sq = 64'(v_abs) * 64'(v_abs + dec);
  assign stop_dist = 32'(brake_sq[63:1] / 63'(dec == 0 ? 32'sd1 : dec));

  always_comb begin
    vcmd = 32'sd0;
    if (stopping) begin
      vcmd = 32'sd0;
    end else if (vel_mode && !homing) begin
      vcmd = clamp(tgt_vel_reg, -vel_limit_reg, vel_limit_reg);
    end else if (hm_reg == hpp_pkg::HPP_H_FAST_OUT &&
                 dist_to_bound[31] != hm_target_reg[31]) begin
      vcmd = 32'sd0;
    end else if (homing && hm_reg != hpp_pkg::HPP_H_DONE) begin
      vcmd = (hm_reg == hpp_pkg::HPP_H_FAST_BACK) ? -hm_dir * vlim :
             hm_dir * vlim;
    end else if (togo == 0) begin
      vcmd = 32'sd0;
    end else if (abs32(togo) <= stop_dist ||
                 (togo[31] != mot_reg.vel[31] && mot_reg.vel != 0)) begin
      vcmd = 32'sd0;
    end else begin
      vcmd = togo[31] ? -vlim : vlim;
    end
  end

  always_comb begin
    v_step = (abs32(vcmd) > v_abs) ? acc : dec;
    lim_hit = 1'b0;
    if (stopping && drv_reg == hpp_pkg::HPP_QUICK_STOP) begin
      v_step = dec;
    end
    if (mot_reg.vel < vcmd) begin
      v_new = (vcmd - mot_reg.vel > v_step) ? mot_reg.vel + v_step : vcmd;
    end else begin
      v_new = (mot_reg.vel - vcmd > v_step) ? mot_reg.vel - v_step : vcmd;
    end
    p_new = mot_reg.pos + v_new;
    // exact landing on the target when the last step would reach or overshoot it
    if (!vel_mode && !homing && !stopping && togo != 0 &&
        abs32(v_new) >= abs32(togo) && v_new[31] == togo[31]) begin
      p_new = goal;
      v_new = 32'sd0;
    end
    if (!vel_mode && p_new != clamp(p_new, pos_min_reg, pos_max_reg)) begin
      p_new = clamp(p_new, pos_min_reg, pos_max_reg);
      lim_hit = !stopping;
      v_new = 32'sd0;
    end
    mot_next = '{pos: p_new, vel: v_new, acc: v_new - mot_reg.vel};
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_reg            <= hpp_pkg::HPP_SW_ON_DISABLED;
      hm_reg             <= hpp_pkg::HPP_H_IDLE;
      mot_reg            <= '0;
      mode_act_reg       <= hpp_pkg::MODE_POSITION;
      homed_reg          <= 1'b0;
      limit_reg          <= 1'b0;
      sw_prev_reg        <= 1'b0;
      fault_rst_prev_reg <= 1'b0;
    end else begin
      drv_reg            <= drv_next;
      hm_reg             <= hm_next;
      sw_prev_reg        <= sw_act;
      fault_rst_prev_reg <= ctrl_reg[hpp_pkg::CW_FAULT_RST];
      mot_reg            <= mot_next;
      limit_reg          <= lim_hit ? 1'b1 : (cw_written ? 1'b0 : limit_reg);
      if (home_ok && method_reg[7:0] == hpp_pkg::METHOD_HERE) begin
        mot_reg.pos  <= hm_offset_reg;
        mot_reg.vel  <= '0;
        homed_reg    <= 1'b1;
        mode_act_reg <= hpp_pkg::MODE_POSITION;
      end else if (hm_reg == hpp_pkg::HPP_H_DONE) begin
        mot_reg.pos  <= hm_offset_reg;
        mot_reg.vel  <= '0;
        homed_reg    <= 1'b1;
        mode_act_reg <= hpp_pkg::MODE_POSITION;
      end else if (home_ok) begin
        mode_act_reg <= hpp_pkg::MODE_HOMING;
        homed_reg    <= 1'b0;
      end else if (mode_wr && !home_req && !homing) begin
        mode_act_reg <= bus.wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg      <= hpp_pkg::RESET_VALUE;
      mode_req_reg  <= 32'(hpp_pkg::MODE_POSITION);
      method_reg    <= hpp_pkg::RESET_VALUE;
      in_sel_reg    <= hpp_pkg::RESET_VALUE;
      pol_reg       <= 32'h0000_0001;
      hm_target_reg <= hpp_pkg::RESET_VALUE;
      hm_vfast_reg  <= hpp_pkg::RESET_VALUE;
      hm_vslow_reg  <= hpp_pkg::RESET_VALUE;
      hm_acc_reg    <= hpp_pkg::RESET_VALUE;
      hm_dec_reg    <= hpp_pkg::RESET_VALUE;
      hm_offset_reg <= hpp_pkg::RESET_VALUE;
      pp_target_reg <= hpp_pkg::RESET_VALUE;
      pp_vel_reg    <= hpp_pkg::RESET_VALUE;
      pp_acc_reg    <= hpp_pkg::RESET_VALUE;
      pp_dec_reg    <= hpp_pkg::RESET_VALUE;
      vel_limit_reg <= 32'h7FFF_FFFF;
      pos_min_reg   <= 32'h8000_0001;
      pos_max_reg   <= 32'h7FFF_FFFF;
      tgt_vel_reg   <= hpp_pkg::RESET_VALUE;
    end else if (bus.wr) begin
      case (bus.addr)
        hpp_pkg::ADDR_CTRL:      ctrl_reg      <= bus.wdata;
        hpp_pkg::ADDR_MODE_REQ:  mode_req_reg  <= bus.wdata;
        hpp_pkg::ADDR_HM_METHOD: method_reg    <= bus.wdata;
        hpp_pkg::ADDR_HM_INPUT:  in_sel_reg    <= bus.wdata;
        hpp_pkg::ADDR_HM_POL:    pol_reg       <= bus.wdata;
        hpp_pkg::ADDR_HM_TARGET: hm_target_reg <= bus.wdata;
        hpp_pkg::ADDR_HM_VFAST:  hm_vfast_reg  <= bus.wdata;
        hpp_pkg::ADDR_HM_VSLOW:  hm_vslow_reg  <= bus.wdata;
        hpp_pkg::ADDR_HM_ACC:    hm_acc_reg    <= bus.wdata;
        hpp_pkg::ADDR_HM_DEC:    hm_dec_reg    <= bus.wdata;
        hpp_pkg::ADDR_HM_OFFSET: hm_offset_reg <= bus.wdata;
        hpp_pkg::ADDR_PP_TARGET: pp_target_reg <= bus.wdata;
        hpp_pkg::ADDR_PP_VEL:    pp_vel_reg    <= bus.wdata;
        hpp_pkg::ADDR_PP_ACC:    pp_acc_reg    <= bus.wdata;
        hpp_pkg::ADDR_PP_DEC:    pp_dec_reg    <= bus.wdata;
        hpp_pkg::ADDR_VEL_LIMIT: vel_limit_reg <= bus.wdata;
        hpp_pkg::ADDR_POS_MIN:   pos_min_reg   <= bus.wdata;
        hpp_pkg::ADDR_POS_MAX:   pos_max_reg   <= bus.wdata;
        hpp_pkg::ADDR_TGT_VEL:   tgt_vel_reg   <= bus.wdata;
        default: ;
      endcase
    end
  end

  logic [31:0] status_word, rd_mux;
  logic        at_target;
  assign at_target = mot_reg.pos == pp_target_reg && mot_reg.vel == 0;
  always_comb begin
    status_word = '0;
    status_word[hpp_pkg::SW_SW_ON_DIS]   = drv_reg == hpp_pkg::HPP_SW_ON_DISABLED;
    status_word[hpp_pkg::SW_RDY_SW_ON]   = drv_reg == hpp_pkg::HPP_READY ||
                                           drv_reg == hpp_pkg::HPP_SWITCHED_ON ||
                                           op_en;
    status_word[hpp_pkg::SW_SWITCHED_ON] = drv_reg == hpp_pkg::HPP_SWITCHED_ON ||
                                           op_en;
    status_word[hpp_pkg::SW_OP_ENABLED]  = op_en;
    status_word[hpp_pkg::SW_FAULT]       = drv_reg == hpp_pkg::HPP_FAULT;
    status_word[hpp_pkg::SW_QUICK_STOP]  = drv_reg != hpp_pkg::HPP_QUICK_STOP;
    status_word[hpp_pkg::SW_TGT_REACHED] = at_target;
    status_word[hpp_pkg::SW_LIMIT]       = limit_reg;
    status_word[hpp_pkg::SW_HOMED]       = homed_reg;
  end

  always_comb begin
    case (bus.addr)
      hpp_pkg::ADDR_CTRL:      rd_mux = ctrl_reg;
      hpp_pkg::ADDR_STATUS:    rd_mux = status_word;
      hpp_pkg::ADDR_MODE_REQ:  rd_mux = mode_req_reg;
      hpp_pkg::ADDR_MODE_ACT:  rd_mux = {24'h000000, mode_act_reg};
      hpp_pkg::ADDR_HM_METHOD: rd_mux = method_reg;
      hpp_pkg::ADDR_HM_TARGET: rd_mux = hm_target_reg;
      hpp_pkg::ADDR_HM_OFFSET: rd_mux = hm_offset_reg;
      hpp_pkg::ADDR_PP_TARGET: rd_mux = pp_target_reg;
      hpp_pkg::ADDR_PP_VEL:    rd_mux = pp_vel_reg;
      hpp_pkg::ADDR_TGT_VEL:   rd_mux = tgt_vel_reg;
      hpp_pkg::ADDR_POS_ACT:   rd_mux = mot_reg.pos;
      hpp_pkg::ADDR_VEL_ACT:   rd_mux = mot_reg.vel;
      hpp_pkg::ADDR_ACC_ACT:   rd_mux = mot_reg.acc;
      default:                 rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : '0;
    end
  end

  assign bus_rdata = rdata_reg;
  assign pos_out   = mot_reg.pos;
  assign vel_out   = mot_reg.vel;

endmodule

// >>> test/hpp_checker.sv
`timescale 1ns/1ps
module hpp_checker #(
  parameter int NUM_INPUTS = 4
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // register port
  input wire logic                  bus_wr,
  input wire logic                  bus_rd,
  input wire logic [4:0]            bus_addr,
  input wire logic [31:0]           bus_wdata,
  input wire logic [31:0]           bus_rdata,
  // pins and motion
  input wire logic [NUM_INPUTS-1:0] din,
  input wire logic signed [31:0]    pos_out,
  input wire logic signed [31:0]    vel_out,
  input wire logic                  drive_enabled
);
  // ------------------------------------------------
  // shadows of the written values
  // ------------------------------------------------
  logic [3:0]         cw_last;
  logic [3:0]         cw_prev;
  logic [7:0]         meth;
  logic signed [31:0] offs;
  logic signed [31:0] vlim;
  wire                wr_ctrl = bus_wr && bus_addr == hpp_pkg::ADDR_CTRL;
  wire                home_req = bus_wr && bus_wdata[7:0] == 8'h06
                                 && bus_addr == hpp_pkg::ADDR_MODE_REQ;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cw_last <= 4'h0;
      cw_prev <= 4'h0;
      meth    <= 8'h00;
      offs    <= 32'sh0;
      vlim    <= 32'sh7FFFFFFF;
    end else if (bus_wr) begin
      if (bus_addr == hpp_pkg::ADDR_CTRL) begin
        cw_last <= bus_wdata[3:0];
        cw_prev <= cw_last;
      end
      if (bus_addr == hpp_pkg::ADDR_HM_METHOD) meth <= bus_wdata[7:0];
      if (bus_addr == hpp_pkg::ADDR_HM_OFFSET) offs <= bus_wdata;
      if (bus_addr == hpp_pkg::ADDR_VEL_LIMIT) vlim <= bus_wdata;
    end
  end

  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_rdata_after_read: assert property (
    bus_rdata != 32'h0 |-> $past(bus_rd)) else $error("stray read data");
  a_unmapped_zero: assert property (
    bus_rd && bus_addr > 5'h17 |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_disable_drops: assert property (
    wr_ctrl && !bus_wdata[1] |-> ##[1:3] !drive_enabled)
    else $error("disable voltage kept drive on");
  a_quick_stop_off: assert property (
    wr_ctrl && bus_wdata[2:1] == 2'b01 |-> ##[1:3] !drive_enabled)
    else $error("quick stop kept drive on");
  a_enable_path: assert property (
    $rose(drive_enabled) |-> cw_last == 4'hF && cw_prev[2:1] == 2'b11)
    else $error("enable without proper command path");
  a_vel_clamped: assert property (
    vel_out <= vlim && vel_out >= -vlim) else $error("velocity over limit");
  a_home_refused: assert property (
    home_req && !drive_enabled |=> $stable(pos_out)[*4])
    else $error("homing moved while not enabled");
  a_home_here: assert property (
    home_req && drive_enabled && meth == hpp_pkg::METHOD_HERE
    |-> ##[1:3] pos_out == offs) else $error("reference not at offset");
endmodule

bind hpp_profile hpp_checker #(.NUM_INPUTS(NUM_INPUTS)) chk (
  .ref_clk(ref_clk), .rst(rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .din(din), .pos_out(pos_out), .vel_out(vel_out),
  .drive_enabled(drive_enabled));

// >>> test/hpp_host_model.sv
`timescale 1ns/1ps
module hpp_host_model (
  // clock
  input  wire logic   ref_clk,
  // register port
  output logic        bus_wr,
  output logic        bus_rd,
  output logic [4:0]  bus_addr,
  output logic [31:0] bus_wdata
);
  // each note is expected data over compare mask
  logic [63:0] note_q[$];

  initial begin
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 5'h00;
    bus_wdata = 32'h0;
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
    // released data must not look like a held value
    bus_wdata <= ~d;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge ref_clk);
    note_q.push_back({e, m});
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
  endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam logic [3:0]  CW_TAB [5] = '{4'h0, 4'hF, 4'h6, 4'h7, 4'hF};
  localparam logic [31:0] ST_TAB [5] = '{32'h60, 32'h60, 32'h21, 32'h23,
                                         32'h27};
  logic               ref_clk = 1'b0;
  logic               rst     = 1'b1;
  logic               bus_wr;
  logic               bus_rd;
  logic [4:0]         bus_addr;
  logic [31:0]        bus_wdata;
  logic [31:0]        bus_rdata;
  logic [3:0]         din     = 4'h0;
  logic signed [31:0] pos_out;
  logic signed [31:0] vel_out;
  logic               drive_enabled;
  logic               rd_seen = 1'b0;
  logic [1:0]         sel     = 2'h0;
  logic               pol     = 1'b1;
  logic signed [31:0] sw_pos  = 32'sh4000_0000;
  logic signed [31:0] offs;
  logic signed [31:0] av;
  logic [31:0]        peak;
  logic [31:0]        pk2;
  logic [63:0]        note;
  logic [3:0]         c;
  int                 mismatches = 0;
  int                 checks = 0;
  int                 k;
  int                 last;
  int                 flips;
  // narrow cam so every crossing gives a fresh edge
  wire hit = pos_out >= sw_pos && pos_out < sw_pos + 32;

  always #5 ref_clk = ~ref_clk;

  hpp_host_model host (.ref_clk(ref_clk), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  hpp_profile #(.NUM_INPUTS(4)) dut (.ref_clk(ref_clk), .rst(rst),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .din(din),
    .pos_out(pos_out), .vel_out(vel_out), .drive_enabled(drive_enabled));

  // unselected inputs carry noise to prove the selection
  always @(posedge ref_clk) begin
    din <= (4'($urandom_range(15, 0)) & ~(4'h1 << sel))
           | ({3'h0, hit ~^ pol} << sel);
  end

  // ------------------------------------------------
  // checking
  // ------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge ref_clk) begin
    if (rd_seen === 1'b1) begin
      note = host.note_q.pop_front();
      cmp(bus_rdata, note[63:32], note[31:0]);
    end
    rd_seen <= bus_rd;
  end

  task automatic check_k(input int lim);
    if (k >= lim) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic track();
    av = vel_out < 0 ? -vel_out : vel_out;
    if (flips < 2 && av > peak) peak = av;
    if (flips >= 2 && av > pk2) pk2 = av;
  endtask

  task automatic wait_stop();
    peak  = 0;
    flips = 0;
    for (k = 0; k < 6000 && !(k > 20 && vel_out === 32'sh0); k++) begin
      @(posedge ref_clk);
      track();
    end
    check_k(6000);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    k = $urandom(32'hE22A);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    host.rd(hpp_pkg::ADDR_MODE_ACT, 32'h1, 32'hFF);
    host.rd(hpp_pkg::ADDR_VEL_ACT, 32'h0, '1);
    host.rd(5'h1F, 32'h0, '1);
    host.wr(hpp_pkg::ADDR_MODE_REQ, 32'h6);
    host.rd(hpp_pkg::ADDR_MODE_ACT, 32'h1, 32'hFF);
    offs = 32'($urandom_range(63, 1));
    host.wr(hpp_pkg::ADDR_HM_METHOD, 32'h25);
    host.wr(hpp_pkg::ADDR_HM_OFFSET, offs);
    host.wr(hpp_pkg::ADDR_PP_VEL, 32'h0);
    host.wr(hpp_pkg::ADDR_MODE_REQ, 32'h1);
    for (int i = 0; i < 5; i++) begin
      c = CW_TAB[i];
      if (i == 2) c[3] = 1'($urandom_range(1, 0));
      host.wr(hpp_pkg::ADDR_CTRL, {28'h0, c});
      repeat (2) @(posedge ref_clk);
      host.rd(hpp_pkg::ADDR_STATUS, ST_TAB[i], 32'h6F);
    end
    host.wr(hpp_pkg::ADDR_MODE_REQ, 32'h6);
    repeat (3) @(posedge ref_clk);
    host.rd(hpp_pkg::ADDR_POS_ACT, offs, '1);
    host.rd(hpp_pkg::ADDR_MODE_ACT, 32'h1, 32'hFF);
    host.rd(hpp_pkg::ADDR_STATUS, 32'h1000, 32'h1000);
    sel    = 2'($urandom_range(3, 0));
    pol    = 1'($urandom_range(1, 0));
    sw_pos = offs + 300;
    host.wr(hpp_pkg::ADDR_HM_INPUT, {30'h0, sel});
    host.wr(hpp_pkg::ADDR_HM_POL, {31'h0, pol});
    host.wr(hpp_pkg::ADDR_HM_TARGET, 32'd1000);
    host.wr(hpp_pkg::ADDR_HM_VFAST, 32'd8);
    host.wr(hpp_pkg::ADDR_HM_VSLOW, 32'd2);
    host.wr(hpp_pkg::ADDR_HM_ACC, 32'd2);
    host.wr(hpp_pkg::ADDR_HM_DEC, 32'd2);
    host.wr(hpp_pkg::ADDR_HM_METHOD, 32'h11);
    host.wr(hpp_pkg::ADDR_MODE_REQ, 32'h6);
    peak  = 0;
    pk2   = 0;
    flips = 0;
    last  = 0;
    for (k = 0; k < 20000 && !(flips >= 2 && vel_out === 32'sh0); k++) begin
      @(posedge ref_clk);
      if (vel_out != 0 && (vel_out > 0 ? 1 : -1) != last) begin
        if (last != 0) flips++;
        last = vel_out > 0 ? 1 : -1;
      end
      track();
    end
    check_k(20000);
    cmp(peak, 32'd8, '1);
    cmp(pk2, 32'd2, '1);
    host.rd(hpp_pkg::ADDR_MODE_ACT, 32'h1, 32'hFF);
    host.rd(hpp_pkg::ADDR_POS_ACT, offs, '1);
    host.wr(hpp_pkg::ADDR_PP_ACC, 32'd2);
    host.wr(hpp_pkg::ADDR_PP_DEC, 32'd2);
    host.wr(hpp_pkg::ADDR_PP_TARGET, 32'd500);
    host.wr(hpp_pkg::ADDR_PP_VEL, 32'd10);
    for (k = 0; k < 3000 && pos_out < 300; k++) @(posedge ref_clk);
    check_k(3000);
    host.wr(hpp_pkg::ADDR_PP_TARGET, -32'sd200);
    wait_stop();
    cmp(peak, 32'd10, '1);
    host.rd(hpp_pkg::ADDR_POS_ACT, -32'sd200, '1);
    host.rd(hpp_pkg::ADDR_STATUS, 32'h400, 32'h400);
    host.wr(hpp_pkg::ADDR_PP_TARGET, -32'sd197);
    wait_stop();
    host.rd(hpp_pkg::ADDR_POS_ACT, -32'sd197, '1);
    host.wr(hpp_pkg::ADDR_VEL_LIMIT, 32'd5);
    host.wr(hpp_pkg::ADDR_POS_MAX, 32'd150);
    host.wr(hpp_pkg::ADDR_PP_TARGET, 32'd400);
    wait_stop();
    cmp(peak, 32'd5, '1);
    host.rd(hpp_pkg::ADDR_STATUS, 32'h800, 32'h800);
    host.wr(hpp_pkg::ADDR_MODE_REQ, 32'h3);
    host.wr(hpp_pkg::ADDR_TGT_VEL, 32'd4);
    for (k = 0; k < 100 && vel_out !== 32'sd4; k++) @(posedge ref_clk);
    check_k(100);
    repeat (80) @(posedge ref_clk);
    host.rd(hpp_pkg::ADDR_VEL_ACT, 32'd4, '1);
    cmp({31'h0, pos_out > 150}, 32'h1, '1);
    host.wr(hpp_pkg::ADDR_TGT_VEL, 32'd0);
    wait_stop();
    host.wr(hpp_pkg::ADDR_CTRL, 32'hB);
    repeat (2) @(posedge ref_clk);
    host.rd(hpp_pkg::ADDR_STATUS, 32'h0, 32'h24);
    host.wr(hpp_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    host.rd(hpp_pkg::ADDR_STATUS, 32'h60, 32'h6F);
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule
